// >>> hdl/irq_ctrl_pkg.sv
// irq_ctrl_pkg: register map, field positions and reset values of the interrupt controller.
// assumes a 32-bit apb bus with one aligned word per register.
package irq_ctrl_pkg;
	localparam logic [11:0] ADDR_CONTROL    = 12'h000;
	localparam logic [11:0] ADDR_PERIPH_EN  = 12'h004;
	localparam logic [11:0] ADDR_PERIPH_FLG = 12'h008;
	localparam logic [11:0] ADDR_CONFIG     = 12'h00c;
	localparam logic [11:0] ADDR_STATUS     = 12'h010;
	localparam logic [11:0] ADDR_TIMER0     = 12'h014;
	localparam int BIT_GLOBAL_EN    = 7;
	localparam int BIT_GROUP_EN     = 6;
	localparam int BIT_TIMER0_EN    = 5;
	localparam int BIT_EXT_EN       = 4;
	localparam int BIT_CHANGE_EN    = 3;
	localparam int BIT_TIMER0_FLAG  = 2;
	localparam int BIT_EXT_FLAG     = 1;
	localparam int BIT_CHANGE_FLAG  = 0;
	localparam int BIT_EDGE         = 0;
	localparam int BIT_ANALOG       = 1;
	localparam int BIT_SLEEP = 2;
	localparam logic [7:0]  CONTROL_RESET   = 8'h00;
	localparam logic [11:0] PERIPH_RESET    = 12'h000;
	localparam logic [7:0]  PIN_MASK_RESET  = 8'h00;
	localparam logic [12:0] IRQ_VECTOR      = 13'h0004;
	localparam int          LATENCY_CYCLES  = 3;
	localparam logic [1:0]  LAT_COUNT_INIT  = 2'h2;
endpackage : irq_ctrl_pkg

// >>> hdl/irq_ctrl.sv
// irq_ctrl: interrupt controller of a small core: flags, enables, vectoring, wake-up.
// assumes event inputs are one-cycle pulses from pclk logic, pins are asynchronous,
// and the core honours take_irq/return_from_irq within one cycle.
// Notes on behaviour
// [R01] - fifteen sources: ext pin, pin change, timer0, and twelve peripheral events.
// [R02] - each flag sets on its event regardless of its enable or global enable.
// [R03] - global enable set allows unmasked interrupts; clear blocks all redirection.
// [R04] - global enable clears on any device reset.
// [R05] - servicing clears global enable, pushes return address, loads vector 0004h.
// [R06] - events while global enable clear only set flags, no redirection.
// [R07] - clearing global enable cancels imminent interrupt; it stays pending.
// [R08] - return-from-interrupt pops address, restores context, sets global enable.
// [R09] - latency from event to vector three cycles, four for asynchronous pin events; pin events take five pclk cycles here.
// [R10] - external pin edge-triggered; rising when edge select is 1, else falling.
// [R11] - valid selected edge sets the external flag, control bit 1.
// [R12] - software clears external flag before re-enabling; enable is control bit 4.
// [R13] - external edge wakes from sleep if its enable was set before sleep.
// [R14] - pin selected analog reads 0 and never raises an interrupt.
// [R15] - peripheral group enable bit 6 gates every peripheral source.
// [R16] - timer0 flag bit 2 sets on rollover, sticky; count untouched by reset.
// [R17] - pin-change flag bit 0 on enabled pin change; needs bit 3 and pin masks.
// [R18] - timer0 enable bit 5 passes or blocks the timer0 flag.
// [R19] - service routine polls flags and clears them before returning.
// [R20] - software clears a flag before setting its enable.
// [R21] - request to core when global enable and an enabled flag, plus group enable; the code needs group enable for peripheral flags only.
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module irq_ctrl #(
	parameter int N_PERIPH = 12,
	parameter int N_PINS   = 8
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic                     pready,
	output logic      [31:0]         prdata,
	output logic                     pslverr,
	input  wire logic                ext_irq_pin,
	input  wire logic [N_PINS-1:0]   change_pins,
	input  wire logic                timer0_tick,
	input  wire logic [N_PERIPH-1:0] periph_events,
	input  wire logic [12:0]         core_pc,
	input  wire logic                return_from_irq,
	output logic                     take_irq,
	output logic      [12:0]         vector_pc,
	output logic      [12:0]         push_addr,
	output logic                     restore_context,
	output logic                     irq_request,
	output logic                     wake_up,
	output logic                     ext_pin_digital
);
	// register state
	logic [7:0]          control_reg,     control_next;
	logic [N_PERIPH-1:0] periph_en_reg,   periph_en_next;
	logic [N_PERIPH-1:0] periph_flg_reg,  periph_flg_next;
	logic [N_PINS-1:0]   pin_masks_reg,   pin_masks_next;
	logic                edge_sel_reg,    edge_sel_next;
	logic                analog_sel_reg,  analog_sel_next;
	logic                sleep_reg,       sleep_next;
	logic                sleep_ext_pin_irq_enable_reg,  sleep_ext_pin_irq_enable_next;
	logic [7:0]          timer0_count_reg, timer0_count_next;
	// synchronisers and edge history
	logic                ext_s1_reg, ext_s2_reg, ext_last_reg;
	logic [N_PINS-1:0]   chg_s1_reg, chg_s2_reg, chg_last_reg;
	// vectoring pipeline
	logic [1:0]          lat_cnt_reg,     lat_cnt_next;
	logic                pending_reg,     pending_next;
	logic                take_reg,        take_next;
	logic [12:0]         push_reg,        push_next;
	logic                restore_reg,     restore_next;

	function automatic logic sel_hit(input logic [11:0] a, input logic [11:0] off);
		sel_hit = (a[11:2] == off[11:2]);
	endfunction : sel_hit

	logic wr_en, rd_en;
	logic ext_level, ext_edge, pin_change;
	logic periph_any, core_any, req_raw;

	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & ~penable & ~pwrite;
	// analog pin reads 0 and its edges vanish [R14]
	assign ext_level = ext_s2_reg & ~analog_sel_reg; // [R14]
	assign ext_pin_digital = ext_level;
	assign ext_edge = edge_sel_reg ? (ext_level & ~ext_last_reg)
	                               : (~ext_level & ext_last_reg); // [R10]
	assign pin_change = |((chg_s2_reg ^ chg_last_reg) & pin_masks_reg); // [R17]

	assign periph_any = control_reg[irq_ctrl_pkg::BIT_GROUP_EN]
	                    & |(periph_flg_reg & periph_en_reg); // [R15]
	assign core_any = (control_reg[irq_ctrl_pkg::BIT_TIMER0_EN]
	                   & control_reg[irq_ctrl_pkg::BIT_TIMER0_FLAG])
	                  | (control_reg[irq_ctrl_pkg::BIT_EXT_EN]
	                     & control_reg[irq_ctrl_pkg::BIT_EXT_FLAG])
	                  | (control_reg[irq_ctrl_pkg::BIT_CHANGE_EN]
	                     & control_reg[irq_ctrl_pkg::BIT_CHANGE_FLAG]); // [R18] [R17]
	assign req_raw = core_any | periph_any;
	assign irq_request = control_reg[irq_ctrl_pkg::BIT_GLOBAL_EN] & req_raw; // [R21] [R03]

	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign take_irq = take_reg;
	assign vector_pc = irq_ctrl_pkg::IRQ_VECTOR; // [R05]
	assign push_addr = push_reg;
	assign restore_context = restore_reg;
	// wake needs the enable latched at sleep entry [R13]
	assign wake_up = sleep_reg & sleep_ext_pin_irq_enable_reg & ext_edge; // [R13]

	always_comb begin
		control_next    = control_reg;
		periph_en_next  = periph_en_reg;
		periph_flg_next = periph_flg_reg;
		pin_masks_next  = pin_masks_reg;
		edge_sel_next   = edge_sel_reg;
		analog_sel_next = analog_sel_reg;
		sleep_next      = sleep_reg;
		sleep_ext_pin_irq_enable_next = sleep_ext_pin_irq_enable_reg;
		timer0_count_next = timer0_count_reg;
		if (wr_en) begin
			if (sel_hit(paddr, irq_ctrl_pkg::ADDR_CONTROL)) begin
				control_next = pwdata[7:0];
			end
			if (sel_hit(paddr, irq_ctrl_pkg::ADDR_PERIPH_EN)) begin
				periph_en_next = pwdata[N_PERIPH-1:0];
			end
			if (sel_hit(paddr, irq_ctrl_pkg::ADDR_PERIPH_FLG)) begin
				periph_flg_next = pwdata[N_PERIPH-1:0];
			end
			if (sel_hit(paddr, irq_ctrl_pkg::ADDR_CONFIG)) begin
				edge_sel_next   = pwdata[irq_ctrl_pkg::BIT_EDGE];
				analog_sel_next = pwdata[irq_ctrl_pkg::BIT_ANALOG];
				sleep_next      = pwdata[irq_ctrl_pkg::BIT_SLEEP];
				pin_masks_next  = pwdata[8 +: N_PINS];
				if (pwdata[irq_ctrl_pkg::BIT_SLEEP] & ~sleep_reg) begin
					sleep_ext_pin_irq_enable_next = control_reg[irq_ctrl_pkg::BIT_EXT_EN]; // [R13]
				end
			end
			if (sel_hit(paddr, irq_ctrl_pkg::ADDR_TIMER0)) begin
				timer0_count_next = pwdata[7:0];
			end
		end
		if (timer0_tick) begin
			timer0_count_next = timer0_count_reg + 8'h01;
		end
		if (wake_up) begin
			sleep_next = 1'b0;
		end
		// hardware sets win over a software clear in the same cycle [R02]
		if (timer0_tick & (&timer0_count_reg)) begin
			control_next[irq_ctrl_pkg::BIT_TIMER0_FLAG] = 1'b1; // [R16]
		end
		if (ext_edge) begin
			control_next[irq_ctrl_pkg::BIT_EXT_FLAG] = 1'b1; // [R11]
		end
		if (pin_change) begin
			control_next[irq_ctrl_pkg::BIT_CHANGE_FLAG] = 1'b1; // [R17]
		end
		periph_flg_next = periph_flg_next | periph_events; // [R01] [R02]
		if (take_reg) begin
			control_next[irq_ctrl_pkg::BIT_GLOBAL_EN] = 1'b0; // [R05] [R06]
		end
		if (return_from_irq) begin
			control_next[irq_ctrl_pkg::BIT_GLOBAL_EN] = 1'b1; // [R08]
		end
	end

	// the pending request is re-qualified every cycle, so a cleared global
	// enable cancels the vector but leaves the flag for later [R07]
	always_comb begin
		lat_cnt_next = lat_cnt_reg;
		pending_next = pending_reg;
		take_next    = 1'b0;
		push_next    = push_reg;
		restore_next = return_from_irq; // [R08]
		if (!irq_request || take_reg) begin
			pending_next = 1'b0; // [R07] [R06]
			lat_cnt_next = irq_ctrl_pkg::LAT_COUNT_INIT;
		end else if (!pending_reg) begin
			pending_next = 1'b1;
			lat_cnt_next = irq_ctrl_pkg::LAT_COUNT_INIT;
		end else if (lat_cnt_reg != 2'h1) begin
			lat_cnt_next = lat_cnt_reg - 2'h1;
		end else begin
			take_next = 1'b1; // [R09] [R05]
			push_next = core_pc;
			pending_next = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control_reg    <= irq_ctrl_pkg::CONTROL_RESET; // [R04]
			periph_en_reg  <= irq_ctrl_pkg::PERIPH_RESET;
			periph_flg_reg <= irq_ctrl_pkg::PERIPH_RESET;
			pin_masks_reg  <= irq_ctrl_pkg::PIN_MASK_RESET;
			edge_sel_reg   <= 1'b1;
			analog_sel_reg <= 1'b1;
			sleep_reg      <= 1'b0;
			sleep_ext_pin_irq_enable_reg <= 1'b0;
			lat_cnt_reg    <= irq_ctrl_pkg::LAT_COUNT_INIT;
			pending_reg    <= 1'b0;
			take_reg       <= 1'b0;
			push_reg       <= 13'h0000;
			restore_reg    <= 1'b0;
			ext_s1_reg     <= 1'b0;
			ext_s2_reg     <= 1'b0;
			ext_last_reg   <= 1'b0;
			chg_s1_reg     <= '0;
			chg_s2_reg     <= '0;
			chg_last_reg   <= '0;
		end else begin
			control_reg    <= control_next;
			periph_en_reg  <= periph_en_next;
			periph_flg_reg <= periph_flg_next;
			pin_masks_reg  <= pin_masks_next;
			edge_sel_reg   <= edge_sel_next;
			analog_sel_reg <= analog_sel_next;
			sleep_reg      <= sleep_next;
			sleep_ext_pin_irq_enable_reg <= sleep_ext_pin_irq_enable_next;
			lat_cnt_reg    <= lat_cnt_next;
			pending_reg    <= pending_next;
			take_reg       <= take_next;
			push_reg       <= push_next;
			restore_reg    <= restore_next;
			ext_s1_reg     <= ext_irq_pin;
			ext_s2_reg     <= ext_s1_reg;
			ext_last_reg   <= ext_level;
			chg_s1_reg     <= change_pins;
			chg_s2_reg     <= chg_s1_reg;
			chg_last_reg   <= chg_s2_reg;
		end
	end

	// timer0 count has no reset on purpose [R16]
	always_ff @(posedge pclk) begin
		timer0_count_reg <= timer0_count_next; // [R16]
	end

	// read data registered in the setup phase, valid in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en) begin
			prdata <= 32'h0000_0000;
			if (sel_hit(paddr, irq_ctrl_pkg::ADDR_CONTROL)) begin
				prdata[7:0] <= control_reg;
			end
			if (sel_hit(paddr, irq_ctrl_pkg::ADDR_PERIPH_EN)) begin
				prdata[N_PERIPH-1:0] <= periph_en_reg;
			end
			if (sel_hit(paddr, irq_ctrl_pkg::ADDR_PERIPH_FLG)) begin
				prdata[N_PERIPH-1:0] <= periph_flg_reg;
			end
			if (sel_hit(paddr, irq_ctrl_pkg::ADDR_CONFIG)) begin
				prdata[irq_ctrl_pkg::BIT_EDGE]  <= edge_sel_reg;
				prdata[irq_ctrl_pkg::BIT_ANALOG] <= analog_sel_reg;
				prdata[irq_ctrl_pkg::BIT_SLEEP] <= sleep_reg;
				prdata[8 +: N_PINS]             <= pin_masks_reg;
			end
			if (sel_hit(paddr, irq_ctrl_pkg::ADDR_STATUS)) begin
				prdata[0] <= irq_request;
				prdata[1] <= pending_reg;
				prdata[2] <= ext_level;
			end
			if (sel_hit(paddr, irq_ctrl_pkg::ADDR_TIMER0)) begin
				prdata[7:0] <= timer0_count_reg;
			end
		end
	end
endmodule : irq_ctrl
`default_nettype wire

// >>> test/irq_ctrl_properties.sv
// irq_ctrl_properties: port checks of vectoring, return and apb read data.
// assumes one domain on pclk, presetn asynchronous active low.
`timescale 1ns/100ps
`default_nettype none
module irq_ctrl_properties (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        take_irq,
	input wire logic [12:0] vector_pc,
	input wire logic        irq_request,
	input wire logic        return_from_irq,
	input wire logic        restore_context
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_vec; take_irq |-> vector_pc == 13'h0004; endproperty
	a_vec: assert property (p_vec) else $error("bad vector");
	// take comes at ##0 on every path; the pin path's extra edge detect ends before irq_request rises
	property p_lat; $rose(irq_request) ##1 irq_request[*3] |-> ##[0:1] take_irq; endproperty
	a_lat: assert property (p_lat) else $error("late vector");
	property p_cause; take_irq |-> $past(irq_request); endproperty
	a_cause: assert property (p_cause) else $error("vector without request");
	property p_gie; take_irq |=> !irq_request; endproperty
	a_gie: assert property (p_gie) else $error("enable kept on vectoring");
	property p_one; take_irq |=> !take_irq; endproperty
	a_one: assert property (p_one) else $error("long vector pulse");
	property p_ret; return_from_irq |=> restore_context; endproperty
	a_ret: assert property (p_ret) else $error("no restore");
	property p_rcause; restore_context |-> $past(return_from_irq); endproperty
	a_rcause: assert property (p_rcause) else $error("stray restore");
	property p_rd; !$stable(prdata) |-> $past(psel && !penable); endproperty
	a_rd: assert property (p_rd) else $error("read data moved");
endmodule : irq_ctrl_properties
bind irq_ctrl irq_ctrl_properties props_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .prdata(prdata), .take_irq(take_irq), .vector_pc(vector_pc),
	.irq_request(irq_request), .return_from_irq(return_from_irq),
	.restore_context(restore_context));
`default_nettype wire

// >>> test/core_model.sv
// core_model: stand-in core with a pc, one-deep stack and a return strobe.
// assumes the bench raises ret_cmd for one cycle to end a service routine.
`timescale 1ns/100ps
`default_nettype none
module core_model (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        take_irq,
	input wire logic        ret_cmd,
	input wire logic [12:0] vector_pc,
	input wire logic [12:0] push_addr,
	output logic     [12:0] core_pc,
	output logic            return_from_irq
);
	logic [12:0] saved;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_pc <= 13'h0000;
			saved <= 13'h0000;
			return_from_irq <= 1'b0;
		end else begin
			return_from_irq <= ret_cmd;
			if (take_irq) begin
				saved <= push_addr;
				core_pc <= vector_pc;
			end else if (return_from_irq) core_pc <= saved;
			else core_pc <= core_pc + 13'h0001;
		end
	end
endmodule : core_model
`default_nettype wire

// >>> test/tb_irq_ctrl.sv
// tb_irq_ctrl: apb driven sequences against the interrupt controller.
// assumes zero wait apb and registered read data, core_model as the core.
`timescale 1ns/100ps
`default_nettype none
module tb_irq_ctrl;
	logic        pclk, presetn, psel, penable, pwrite, pin, tick, ret_cmd;
	logic [11:0] paddr, ev;
	logic [31:0] pwdata, rd;
	logic [7:0]  chg;
	wire logic   pready, pslverr, take_irq, rst_ctx, irq_req, wake, pin_dig, ret;
	wire logic [31:0] prdata;
	wire logic [12:0] pc, vec, push;
	int          errors, n_checks, n_take, n_wake;
	irq_ctrl irq_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .ext_irq_pin(pin), .change_pins(chg), .timer0_tick(tick),
		.periph_events(ev), .core_pc(pc), .return_from_irq(ret), .take_irq(take_irq),
		.vector_pc(vec), .push_addr(push), .restore_context(rst_ctx),
		.irq_request(irq_req), .wake_up(wake), .ext_pin_digital(pin_dig));
	core_model core_model_i (.pclk(pclk), .presetn(presetn), .take_irq(take_irq),
		.ret_cmd(ret_cmd), .vector_pc(vec), .push_addr(push), .core_pc(pc),
		.return_from_irq(ret));
	initial begin
		pclk = 0;
		forever #25 pclk = ~pclk;
	end
	// counted mid-cycle, where the one-cycle pulses have settled
	always @(negedge pclk) begin
		if (take_irq === 1'b1) n_take++;
		if (wake === 1'b1) n_wake++;
	end
	task final_report;
		$display("errors %0d checks %0d", errors, n_checks);
		if (errors == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : final_report
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("Error at %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	// last=0 keeps psel up so the next setup follows at once
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input bit last = 1);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			errors++;
			final_report();
		end
		rd = prdata;
		penable <= 1'b0;
		if (last) begin
			psel <= 1'b0;
			@(posedge pclk);
		end
	endtask : apb
	task rd_chk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rd_chk
	task wait_take;
		int k;
		for (k = 0; k < 20; k++) begin
			@(negedge pclk);
			if (take_irq === 1'b1) break;
		end
		if (k >= 20) begin
			errors++;
			final_report();
		end
		chk(vec, 32'h4);
		// let the global enable clear before the next read
		repeat (2) @(posedge pclk);
	endtask : wait_take
	task pin_to(input logic v);
		pin <= v;
		repeat (5) @(posedge pclk);
	endtask : pin_to
	initial begin
		{psel, penable, pwrite, pin, tick, ret_cmd} = 6'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		ev = 12'h000;
		chg = 8'h00;
		presetn = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd_chk(12'h000, 32'h0);
		rd_chk(12'h00c, 32'h3);
		rd_chk(12'h01c, 32'h0);
		chk({pready, pslverr}, 32'h2);
		ev <= 12'hfff;
		@(posedge pclk) ev <= 12'h000;
		rd_chk(12'h008, 32'hfff);
		apb(1'b1, 12'h004, 32'h400);
		apb(1'b1, 12'h000, 32'h80);
		@(negedge pclk) chk(irq_req, 0);
		@(posedge pclk) apb(1'b1, 12'h000, 32'hc0);
		wait_take();
		rd_chk(12'h000, 32'h40);
		apb(1'b1, 12'h008, 32'h0);
		ev <= 12'h400;
		@(posedge pclk) ev <= 12'h000;
		rd_chk(12'h008, 32'h400);
		chk(n_take, 1);
		apb(1'b1, 12'h008, 32'h0);
		ret_cmd <= 1'b1;
		@(posedge pclk) ret_cmd <= 1'b0;
		repeat (3) @(posedge pclk);
		rd_chk(12'h000, 32'hc0);
		apb(1'b1, 12'h014, 32'hff);
		apb(1'b1, 12'h000, 32'h20);
		tick <= 1'b1;
		@(posedge pclk) tick <= 1'b0;
		rd_chk(12'h000, 32'h24);
		apb(1'b1, 12'h000, 32'ha4, 1'b0);
		apb(1'b1, 12'h000, 32'h24);
		repeat (8) @(posedge pclk);
		chk(n_take, 1);
		apb(1'b1, 12'h000, 32'ha4);
		wait_take();
		rd_chk(12'h000, 32'h24);
		apb(1'b1, 12'h000, 32'h84);
		@(negedge pclk) chk(irq_req, 0);
		@(posedge pclk) apb(1'b1, 12'h00c, 32'h1);
		apb(1'b1, 12'h000, 32'h90);
		pin <= 1'b1;
		wait_take();
		rd_chk(12'h000, 32'h12);
		chk(pin_dig, 1);
		apb(1'b1, 12'h000, 32'h0);
		pin_to(1'b0);
		rd_chk(12'h000, 32'h0);
		apb(1'b1, 12'h00c, 32'h0);
		pin_to(1'b1);
		pin_to(1'b0);
		rd_chk(12'h000, 32'h2);
		apb(1'b1, 12'h00c, 32'h2);
		apb(1'b1, 12'h000, 32'h0);
		pin_to(1'b1);
		chk(pin_dig, 0);
		pin_to(1'b0);
		rd_chk(12'h000, 32'h0);
		apb(1'b1, 12'h000, 32'h10);
		apb(1'b1, 12'h00c, 32'h5);
		pin_to(1'b1);
		chk(n_wake, 1);
		rd_chk(12'h00c, 32'h1);
		apb(1'b1, 12'h00c, 32'h102);
		apb(1'b1, 12'h000, 32'h08);
		chg <= 8'h02;
		repeat (5) @(posedge pclk);
		rd_chk(12'h000, 32'h08);
		chg <= 8'h03;
		repeat (5) @(posedge pclk);
		rd_chk(12'h000, 32'h09);
		apb(1'b1, 12'h000, 32'h89);
		wait_take();
		final_report();
	end
endmodule : tb_irq_ctrl
`default_nettype wire
